// >>> ptpr_consts.svh
// Purpose: offsets, field positions, reset values and encodings of the port delay/stamp bank
// Assumes: included by bare name from every design file that needs it
// Notes:   register offsets are word indices; the bus byte address is four times the index
`ifndef PTPR_CONSTS_SVH
`define PTPR_CONSTS_SVH

// ************************************************************
// register indices (byte address = index * 4)
// ************************************************************
`define PTPR_IDX_W              12
`define PTPR_IDX_ASYM           12'h644
`define PTPR_IDX_LINK_DLY       12'h646
`define PTPR_IDX_REQ_LO         12'h648
`define PTPR_IDX_REQ_HI         12'h64A
`define PTPR_IDX_SYNC_LO        12'h64C
`define PTPR_IDX_SYNC_HI        12'h64E
`define PTPR_IDX_PRESP_LO       12'h650
`define PTPR_IDX_PRESP_HI       12'h652

// ************************************************************
// bus geometry
// ************************************************************
`define PTPR_ADDR_TOP_LSB       14
`define PTPR_REG_W              16
`define PTPR_HSIZE_WORD         3'h2

// ************************************************************
// field positions
// ************************************************************
`define PTPR_ASYM_SIGN_BIT      15
`define PTPR_ASYM_MAG_MSB       14
`define PTPR_ASYM_MAG_W         15
`define PTPR_HI_SEC_MSB         15
`define PTPR_HI_SEC_LSB         14
`define PTPR_HI_NS_MSB          13
`define PTPR_NS_W               30
`define PTPR_NS_LO_MSB          15
`define PTPR_NS_HI_LSB          16
`define PTPR_NS_HI_MSB          29
`define PTPR_SEC_W              2

// ************************************************************
// reset values
// ************************************************************
`define PTPR_RST_ASYM           16'h0000
`define PTPR_RST_LINK_DLY       16'h0000
`define PTPR_RST_STAMP          16'h0000
`define PTPR_RST_RDATA          32'h0000_0000

// ************************************************************
// message type codes and correction field scaling
// ************************************************************
`define PTPR_MSG_W              4
`define PTPR_MSG_SYNC           4'h0
`define PTPR_MSG_DELAY_REQ      4'h1
`define PTPR_MSG_PDELAY_REQ     4'h2
`define PTPR_MSG_PDELAY_RESP    4'h3
`define PTPR_CORR_W             64
`define PTPR_CORR_FRAC          16

`endif

// >>> ptpr_corr_adj.sv
// Purpose: applies the signed asymmetry correction to one direction's correction field
// Assumes: correction field is scaled nanoseconds with FRAC_BITS fraction bits
// Notes:   one cycle of latency; messages of other types pass through unchanged
`include "ptpr_consts.svh"

module ptpr_corr_adj #(
	parameter int CORR_W    = `PTPR_CORR_W,
	parameter int FRAC_BITS = `PTPR_CORR_FRAC,
	parameter bit SUBTRACT  = 1'b0
) (
	input  wire logic                          sys_clk,
	input  wire logic                          reset,
	input  wire logic                          in_valid,
	input  wire logic [`PTPR_MSG_W-1:0]        in_msg_type,
	input  wire logic [CORR_W-1:0]             in_corr,
	input  wire logic                          asym_sign,
	input  wire logic [`PTPR_ASYM_MAG_W-1:0]   asym_mag,
	output logic                               out_valid,
	output logic [CORR_W-1:0]                  out_corr
);

	localparam int PAD_W = CORR_W - `PTPR_ASYM_MAG_W - FRAC_BITS;

	logic                 match;
	logic                 neg;
	logic [CORR_W-1:0]    delta;

	// ************************************************************
	// message selection and signed delta
	// ************************************************************

	// egress path works on requests, ingress path on sync and peer response
	always_comb
	begin
		if (SUBTRACT)
			match = (in_msg_type == `PTPR_MSG_DELAY_REQ) ||
			        (in_msg_type == `PTPR_MSG_PDELAY_REQ);
		else
			match = (in_msg_type == `PTPR_MSG_SYNC) ||
			        (in_msg_type == `PTPR_MSG_PDELAY_RESP);
	end

	// magnitude scaled into correction units
	assign delta = {{PAD_W{1'b0}}, asym_mag, {FRAC_BITS{1'b0}}};

	// sign bit flips the direction of the magnitude
	assign neg = asym_sign ^ SUBTRACT;

	// ************************************************************
	// registered result
	// ************************************************************

	// valid follows input by one cycle
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			out_valid <= 1'b0;
		else
			out_valid <= in_valid;
	end

	// add or subtract the delta on matching messages only
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			out_corr <= '0;
		else if (in_valid && match && neg)
			out_corr <= in_corr - delta;
		else if (in_valid && match)
			out_corr <= in_corr + delta;
		else if (in_valid)
			out_corr <= in_corr;
	end

endmodule // ptpr_corr_adj

// >>> ptpr_pkg.sv
// Purpose: shared types of the port delay/stamp bank
// Assumes: constants live in ptpr_consts.svh
// Notes:   used by scoped name only, never imported
package ptpr_pkg;

	// ************************************************************
	// which egress stamp pair a capture pulse targets
	// ************************************************************
	typedef enum logic [1:0]
	{
		PTPR_STAMP_REQ   = 2'h0,
		PTPR_STAMP_SYNC  = 2'h1,
		PTPR_STAMP_PRESP = 2'h3
	} ptpr_stamp_kind_t;

	// ************************************************************
	// bus slave phase
	// ************************************************************
	typedef enum logic [1:0]
	{
		PTPR_BUS_IDLE = 2'h0,
		PTPR_BUS_RDWT = 2'h1,
		PTPR_BUS_RDDN = 2'h3
	} ptpr_bus_state_t;

endpackage : ptpr_pkg

// >>> ptpr_port_regs.sv
// Purpose: AHB-Lite register bank for port asymmetry, link delay and egress stamps
// Assumes: frame path and stamp source run on sys_clk; single word transfers only
// Notes:   writes take no wait state, reads take one; responses are always OKAY
//
// What this block does
// - asymmetry top bit set means negative fifteen-bit magnitude, clear means positive.
// - received Sync and peer response add the asymmetry into correction field.
// - transmitted delay and peer requests subtract the asymmetry from correction field.
// - sixteen-bit read-write link delay in nanoseconds, reset to zero.
// - request egress stamp low word holds nanosecond bits fifteen to zero.
// - request high word: seconds one-zero on top, nanoseconds twenty-nine-sixteen below.
// - Sync egress stamp low word holds nanosecond bits fifteen to zero.
// - Sync high word: seconds one-zero on top, nanoseconds twenty-nine-sixteen below.
// - peer response egress stamp low word holds nanosecond bits fifteen to zero.
// - peer response high word: seconds one-zero top, nanoseconds twenty-nine-sixteen below.
//
// Chosen here: the AHB-Lite interface to the registers.
`include "ptpr_consts.svh"

module ptpr_port_regs #(
	parameter int CORR_W    = `PTPR_CORR_W,
	parameter int FRAC_BITS = `PTPR_CORR_FRAC
) (
	input  wire logic                       sys_clk,
	input  wire logic                       reset,
	// AHB-Lite slave
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic                            hreadyout,
	output logic [31:0]                     hrdata,
	output logic                            hresp,
	// ingress correction path
	input  wire logic                       rx_corr_valid,
	input  wire logic [`PTPR_MSG_W-1:0]     rx_msg_type,
	input  wire logic [CORR_W-1:0]          rx_corr_in,
	output logic                            rx_corr_out_valid,
	output logic [CORR_W-1:0]               rx_corr_out,
	// egress correction path
	input  wire logic                       tx_corr_valid,
	input  wire logic [`PTPR_MSG_W-1:0]     tx_msg_type,
	input  wire logic [CORR_W-1:0]          tx_corr_in,
	output logic                            tx_corr_out_valid,
	output logic [CORR_W-1:0]               tx_corr_out,
	// egress stamp capture
	input  wire logic                       stamp_valid,
	input  wire logic [1:0]                 stamp_kind,
	input  wire logic [`PTPR_SEC_W-1:0]     stamp_sec,
	input  wire logic [`PTPR_NS_W-1:0]      stamp_ns,
	// link delay for the timing correction logic
	output logic [`PTPR_REG_W-1:0]          link_delay_ns
);

	// ************************************************************
	// declarations
	// ************************************************************
	logic [`PTPR_REG_W-1:0]   asym_q;
	logic [`PTPR_REG_W-1:0]   link_dly_q;
	logic [`PTPR_REG_W-1:0]   req_lo_q;
	logic [`PTPR_REG_W-1:0]   req_hi_q;
	logic [`PTPR_REG_W-1:0]   sync_lo_q;
	logic [`PTPR_REG_W-1:0]   sync_hi_q;
	logic [`PTPR_REG_W-1:0]   presp_lo_q;
	logic [`PTPR_REG_W-1:0]   presp_hi_q;

	logic                     addr_ok;
	logic                     take;
	logic                     wr_pend_q;
	logic [`PTPR_IDX_W-1:0]   wr_idx_q;
	logic [`PTPR_IDX_W-1:0]   rd_idx_q;
	logic [`PTPR_REG_W-1:0]   rd_val;
	logic [31:0]              hrdata_q;
	ptpr_pkg::ptpr_bus_state_t bus_q;

	logic [`PTPR_REG_W-1:0]   cap_lo;
	logic [`PTPR_REG_W-1:0]   cap_hi;
	logic                     cap_req;
	logic                     cap_sync;
	logic                     cap_presp;
	logic [`PTPR_REG_W-1:0]   wdat;

	// ************************************************************
	// bus address decode
	// ************************************************************

	// aligned word inside the low window, whole word transfers only
	assign addr_ok = (haddr[31:`PTPR_ADDR_TOP_LSB] == '0) && (haddr[1:0] == 2'h0) &&
	                 (hsize == `PTPR_HSIZE_WORD);
	// the read's last data cycle has hready high, so it takes the next address phase too
	assign take    = hsel && htrans[1] && hready && (bus_q != ptpr_pkg::PTPR_BUS_RDWT);

	// write address phase remembered for its data phase
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= '0;
		end
		else
		begin
			wr_pend_q <= take && hwrite && addr_ok;
			if (take && hwrite)
				wr_idx_q <= haddr[`PTPR_ADDR_TOP_LSB-1:2];
		end
	end

	// read phase sequencer: one wait cycle lets a preceding write land
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			bus_q    <= ptpr_pkg::PTPR_BUS_IDLE;
			rd_idx_q <= '0;
		end
		else
		begin
			case (bus_q)
				ptpr_pkg::PTPR_BUS_IDLE, ptpr_pkg::PTPR_BUS_RDDN:
				begin
					if (take && !hwrite)
					begin
						bus_q    <= ptpr_pkg::PTPR_BUS_RDWT;
						rd_idx_q <= addr_ok ? haddr[`PTPR_ADDR_TOP_LSB-1:2] : '0;
					end
					else
						bus_q <= ptpr_pkg::PTPR_BUS_IDLE;
				end
				ptpr_pkg::PTPR_BUS_RDWT:
					bus_q <= ptpr_pkg::PTPR_BUS_RDDN;
				default:
					bus_q <= ptpr_pkg::PTPR_BUS_IDLE;
			endcase
		end
	end

	// read mux, unmapped indices read as zero
	always_comb
	begin
		case (rd_idx_q)
			`PTPR_IDX_ASYM:     rd_val = asym_q;
			`PTPR_IDX_LINK_DLY: rd_val = link_dly_q;
			`PTPR_IDX_REQ_LO:   rd_val = req_lo_q;
			`PTPR_IDX_REQ_HI:   rd_val = req_hi_q;
			`PTPR_IDX_SYNC_LO:  rd_val = sync_lo_q;
			`PTPR_IDX_SYNC_HI:  rd_val = sync_hi_q;
			`PTPR_IDX_PRESP_LO: rd_val = presp_lo_q;
			`PTPR_IDX_PRESP_HI: rd_val = presp_hi_q;
			default:            rd_val = '0;
		endcase
	end

	// read data registered in the wait cycle, upper bits zero
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			hrdata_q <= `PTPR_RST_RDATA;
		else if (bus_q == ptpr_pkg::PTPR_BUS_RDWT)
			hrdata_q <= {16'h0000, rd_val};
	end

	assign hrdata    = hrdata_q;
	assign hreadyout = (bus_q != ptpr_pkg::PTPR_BUS_RDWT);
	assign hresp     = 1'b0;
	assign wdat      = hwdata[`PTPR_REG_W-1:0];

	// ************************************************************
	// control registers
	// ************************************************************

	// signed asymmetry correction, software only
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			asym_q <= `PTPR_RST_ASYM;
		else if (wr_pend_q && (wr_idx_q == `PTPR_IDX_ASYM))
			asym_q <= wdat;
	end

	// link delay toward the partner, nanoseconds
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			link_dly_q <= `PTPR_RST_LINK_DLY;
		else if (wr_pend_q && (wr_idx_q == `PTPR_IDX_LINK_DLY))
			link_dly_q <= wdat;
	end

	assign link_delay_ns = link_dly_q;

	// ************************************************************
	// egress stamp capture
	// ************************************************************

	// split the stamp into the low and high word layouts
	assign cap_lo = stamp_ns[`PTPR_NS_LO_MSB:0];
	assign cap_hi = {stamp_sec, stamp_ns[`PTPR_NS_HI_MSB:`PTPR_NS_HI_LSB]};

	assign cap_req   = stamp_valid && (stamp_kind == ptpr_pkg::PTPR_STAMP_REQ);
	assign cap_sync  = stamp_valid && (stamp_kind == ptpr_pkg::PTPR_STAMP_SYNC);
	assign cap_presp = stamp_valid && (stamp_kind == ptpr_pkg::PTPR_STAMP_PRESP);

	// request stamp pair; capture beats a software write in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			req_lo_q <= `PTPR_RST_STAMP;
			req_hi_q <= `PTPR_RST_STAMP;
		end
		else if (cap_req)
		begin
			req_lo_q <= cap_lo;
			req_hi_q <= cap_hi;
		end
		else if (wr_pend_q)
		begin
			if (wr_idx_q == `PTPR_IDX_REQ_LO)
				req_lo_q <= wdat;
			if (wr_idx_q == `PTPR_IDX_REQ_HI)
				req_hi_q <= wdat;
		end
	end

	// sync stamp pair
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			sync_lo_q <= `PTPR_RST_STAMP;
			sync_hi_q <= `PTPR_RST_STAMP;
		end
		else if (cap_sync)
		begin
			sync_lo_q <= cap_lo;
			sync_hi_q <= cap_hi;
		end
		else if (wr_pend_q)
		begin
			if (wr_idx_q == `PTPR_IDX_SYNC_LO)
				sync_lo_q <= wdat;
			if (wr_idx_q == `PTPR_IDX_SYNC_HI)
				sync_hi_q <= wdat;
		end
	end

	// peer response stamp pair
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			presp_lo_q <= `PTPR_RST_STAMP;
			presp_hi_q <= `PTPR_RST_STAMP;
		end
		else if (cap_presp)
		begin
			presp_lo_q <= cap_lo;
			presp_hi_q <= cap_hi;
		end
		else if (wr_pend_q)
		begin
			if (wr_idx_q == `PTPR_IDX_PRESP_LO)
				presp_lo_q <= wdat;
			if (wr_idx_q == `PTPR_IDX_PRESP_HI)
				presp_hi_q <= wdat;
		end
	end

	// ************************************************************
	// correction field adjusters
	// ************************************************************

	// ingress: sync and peer response add the signed asymmetry
	ptpr_corr_adj #(
		.CORR_W    (CORR_W),
		.FRAC_BITS (FRAC_BITS),
		.SUBTRACT  (1'b0)
	) u_rx_adj (
		.sys_clk     (sys_clk),
		.reset       (reset),
		.in_valid    (rx_corr_valid),
		.in_msg_type (rx_msg_type),
		.in_corr     (rx_corr_in),
		.asym_sign   (asym_q[`PTPR_ASYM_SIGN_BIT]),
		.asym_mag    (asym_q[`PTPR_ASYM_MAG_MSB:0]),
		.out_valid   (rx_corr_out_valid),
		.out_corr    (rx_corr_out)
	);

	// egress: delay and peer requests subtract the signed asymmetry
	ptpr_corr_adj #(
		.CORR_W    (CORR_W),
		.FRAC_BITS (FRAC_BITS),
		.SUBTRACT  (1'b1)
	) u_tx_adj (
		.sys_clk     (sys_clk),
		.reset       (reset),
		.in_valid    (tx_corr_valid),
		.in_msg_type (tx_msg_type),
		.in_corr     (tx_corr_in),
		.asym_sign   (asym_q[`PTPR_ASYM_SIGN_BIT]),
		.asym_mag    (asym_q[`PTPR_ASYM_MAG_MSB:0]),
		.out_valid   (tx_corr_out_valid),
		.out_corr    (tx_corr_out)
	);

endmodule // ptpr_port_regs

// >>> ptpr_port_regs_monitor.sv
// Purpose: bus, correction and link delay checks at the bank's ports
// Assumes: one clock domain, synchronous active high reset
// Notes:   bound to ptpr_port_regs from the bench top
`include "ptpr_consts.svh"

module ptpr_port_regs_mon #(
	parameter int CORR_W = `PTPR_CORR_W
) (
	input wire logic                   sys_clk,
	input wire logic                   reset,
	input wire logic                   hsel,
	input wire logic [31:0]            haddr,
	input wire logic [1:0]             htrans,
	input wire logic                   hwrite,
	input wire logic [2:0]             hsize,
	input wire logic [31:0]            hwdata,
	input wire logic                   hready,
	input wire logic                   hreadyout,
	input wire logic                   hresp,
	input wire logic                   rx_corr_valid,
	input wire logic [`PTPR_MSG_W-1:0] rx_msg_type,
	input wire logic [CORR_W-1:0]      rx_corr_in,
	input wire logic                   rx_corr_out_valid,
	input wire logic [CORR_W-1:0]      rx_corr_out,
	input wire logic                   tx_corr_valid,
	input wire logic [`PTPR_MSG_W-1:0] tx_msg_type,
	input wire logic [CORR_W-1:0]      tx_corr_in,
	input wire logic                   tx_corr_out_valid,
	input wire logic [CORR_W-1:0]      tx_corr_out,
	input wire logic                   stamp_valid,
	input wire logic [1:0]             stamp_kind,
	input wire logic [`PTPR_REG_W-1:0] link_delay_ns
);
	// ************************************************************
	// mapped span and transfer qualifier
	// ************************************************************
	localparam logic [31:0] A_LO  = {18'h0, `PTPR_IDX_ASYM, 2'h0};
	localparam logic [31:0] A_HI  = {18'h0, `PTPR_IDX_PRESP_HI, 2'h0};
	localparam logic [31:0] A_LNK = {18'h0, `PTPR_IDX_LINK_DLY, 2'h0};
	logic req;
	assign req = hsel && htrans[1] && hready;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// ************************************************************
	// assertions
	// ************************************************************
	a_write_no_wait: assert property (req && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	a_read_one_wait: assert property (req && !hwrite && hsize == `PTPR_HSIZE_WORD
		&& haddr inside {[A_LO:A_HI]} && haddr[2:0] == 3'h0 |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_link_write: assert property (
		req && hwrite && hsize == `PTPR_HSIZE_WORD && haddr == A_LNK
		|=> ##1 link_delay_ns == $past(hwdata[15:0]))
		else $error("link delay output not updated");
	a_rx_valid_lat: assert property (rx_corr_valid |=> rx_corr_out_valid)
		else $error("rx result late");
	a_rx_no_spur: assert property (rx_corr_out_valid |-> $past(rx_corr_valid))
		else $error("rx result without request");
	a_tx_valid_lat: assert property (tx_corr_valid |=> tx_corr_out_valid)
		else $error("tx result late");
	a_rx_pass: assert property (rx_corr_valid && !(rx_msg_type inside
		{`PTPR_MSG_SYNC, `PTPR_MSG_PDELAY_RESP}) |=> rx_corr_out == $past(rx_corr_in))
		else $error("rx other message altered");
	a_tx_pass: assert property (tx_corr_valid && !(tx_msg_type inside
		{`PTPR_MSG_DELAY_REQ, `PTPR_MSG_PDELAY_REQ}) |=> tx_corr_out == $past(tx_corr_in))
		else $error("tx other message altered");

	// main scenarios reached
	c_read: cover property (req && !hwrite);
	c_stamp: cover property (stamp_valid && stamp_kind == 2'h3);
	c_rx: cover property (rx_corr_out_valid);
endmodule // ptpr_port_regs_mon

// >>> tb_ptp_port_delay_timestamp_regs.sv
// Purpose: self-checking bench for the port delay and egress stamp bank
// Assumes: AHB-Lite single word transfers, one slave
// Notes:   random values from a fixed seed, corner cases mixed in
`include "ptpr_consts.svh"

module tb_ptp_port_delay_timestamp_regs;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk, reset, hsel, hwrite, hreadyout, hresp, stamp_valid;
	logic        rx_corr_valid, rx_corr_out_valid, tx_corr_valid, tx_corr_out_valid;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, stamp_kind, stamp_sec;
	logic [2:0]  hsize;
	logic [3:0]  rx_msg_type, tx_msg_type;
	logic [63:0] rx_corr_in, rx_corr_out, tx_corr_in, tx_corr_out;
	logic [29:0] stamp_ns;
	logic [15:0] link_delay_ns;
	wire logic   hready;
	int          fails, n_compared;

	assign hready = hreadyout;

	ptpr_port_regs i_dut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.rx_corr_valid(rx_corr_valid), .rx_msg_type(rx_msg_type), .rx_corr_in(rx_corr_in),
		.rx_corr_out_valid(rx_corr_out_valid), .rx_corr_out(rx_corr_out),
		.tx_corr_valid(tx_corr_valid), .tx_msg_type(tx_msg_type), .tx_corr_in(tx_corr_in),
		.tx_corr_out_valid(tx_corr_out_valid), .tx_corr_out(tx_corr_out),
		.stamp_valid(stamp_valid), .stamp_kind(stamp_kind), .stamp_sec(stamp_sec),
		.stamp_ns(stamp_ns), .link_delay_ns(link_delay_ns));

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk64(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one single transfer, held until hready is seen high
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
		input logic [2:0] sz, output logic [31:0] q);
		@(posedge sys_clk);
		hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr; hsize <= sz;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	function automatic logic [31:0] ra(input int i);
		return {18'h0, 12'(`PTPR_IDX_ASYM + 2 * i), 2'h0};
	endfunction

	// corrected field for one direction and message type
	function automatic logic [63:0] exp_corr(input logic tx, input logic [3:0] ty,
		input logic [15:0] a, input logic [63:0] c);
		logic [63:0] d;
		logic        hit;
		d = {33'h0, a[14:0], 16'h0};
		hit = tx ? (ty == `PTPR_MSG_DELAY_REQ || ty == `PTPR_MSG_PDELAY_REQ)
			: (ty == `PTPR_MSG_SYNC || ty == `PTPR_MSG_PDELAY_RESP);
		if (!hit)
			return c;
		return (tx ^ a[15]) ? c - d : c + d;
	endfunction

	task automatic test_done;
		if (fails == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ************************************************************
	// clock and watchdog
	// ************************************************************
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	initial
	begin
		repeat (5000) @(posedge sys_clk);
		fails++;
		test_done;
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		logic [31:0] q;
		logic [31:0] e[8];
		logic [15:0] a;
		logic [63:0] c;
		logic [29:0] n;
		int          ix;
		int          kd;
		{hsel, hwrite, stamp_valid, rx_corr_valid, tx_corr_valid} = '0;
		{haddr, hwdata, htrans, hsize, stamp_kind, stamp_sec, stamp_ns} = '0;
		{rx_msg_type, tx_msg_type, rx_corr_in, tx_corr_in} = '0;
		fails = 0;
		n_compared = 0;
		reset = 1'b1;
		void'($urandom(53));
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		// reset values, then random write and read back
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b0, ra(i), 32'h0, 3'h2, q);
			chk("reset value", 32'h0, q);
			e[i] = $urandom;
			bus(1'b1, ra(i), e[i], 3'h2, q);
			e[i] = {16'h0, e[i][15:0]};
		end
		chk("link delay port", e[1], {16'h0, link_delay_ns});
		// byte access and reserved address are dropped
		bus(1'b1, ra(0), 32'h0000_ABCD, 3'h0, q);
		bus(1'b0, ra(0), 32'h0, 3'h0, q);
		chk("byte read", 32'h0, q);
		bus(1'b1, ra(8), 32'h0000_1234, 3'h2, q);
		bus(1'b0, ra(8), 32'h0, 3'h2, q);
		chk("reserved read", 32'h0, q);
		// one capture of each kind, kind 2 last so it must leave every pair alone
		for (int k = 0; k < 4; k++)
		begin
			n = 30'($urandom);
			kd = (k + 3) % 4;
			@(posedge sys_clk);
			stamp_valid <= 1'b1;
			stamp_kind <= 2'(kd);
			stamp_sec <= 2'(kd);
			stamp_ns <= n;
			@(posedge sys_clk);
			stamp_valid <= 1'b0;
			ix = (kd == 3) ? 6 : 2 + 2 * kd;
			if (kd != 2)
			begin
				e[ix] = {16'h0, n[15:0]};
				e[ix + 1] = {16'h0, 2'(kd), n[29:16]};
			end
		end
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b0, ra(i), 32'h0, 3'h2, q);
			chk("register word", e[i], q);
		end
		// both directions, every message type, magnitude and sign corners
		for (int t = 0; t < 6; t++)
		begin
			a = (t == 0) ? 16'h7FFF : (t == 1) ? 16'hFFFF : 16'($urandom);
			bus(1'b1, ra(0), {16'h0, a}, 3'h2, q);
			for (int m = 0; m < 4; m++)
			begin
				c = {$urandom, $urandom};
				@(posedge sys_clk);
				rx_corr_valid <= 1'b1;
				tx_corr_valid <= 1'b1;
				rx_msg_type <= 4'(m);
				tx_msg_type <= 4'(m);
				rx_corr_in <= c;
				tx_corr_in <= ~c;
				@(posedge sys_clk);
				rx_corr_valid <= 1'b0;
				tx_corr_valid <= 1'b0;
				#1;
				chk64("rx corr", exp_corr(1'b0, 4'(m), a, c), rx_corr_out);
				chk64("tx corr", exp_corr(1'b1, 4'(m), a, ~c), tx_corr_out);
			end
		end
		test_done;
	end
endmodule // tb_ptp_port_delay_timestamp_regs

bind ptpr_port_regs ptpr_port_regs_mon #(.CORR_W(CORR_W)) i_mon (.sys_clk(sys_clk),
	.reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.rx_corr_valid(rx_corr_valid), .rx_msg_type(rx_msg_type), .rx_corr_in(rx_corr_in),
	.rx_corr_out_valid(rx_corr_out_valid), .rx_corr_out(rx_corr_out),
	.tx_corr_valid(tx_corr_valid), .tx_msg_type(tx_msg_type), .tx_corr_in(tx_corr_in),
	.tx_corr_out_valid(tx_corr_out_valid), .tx_corr_out(tx_corr_out),
	.stamp_valid(stamp_valid), .stamp_kind(stamp_kind), .link_delay_ns(link_delay_ns));
